/* File: pmcmd_pkg.sv */
package pmcmd_pkg;

   // Command codes on the PMBus command port
   localparam logic [7:0] CMD_START_STOP_CONFIG = 8'h02;
   localparam logic [7:0] CMD_FAULT_FLAG_WIPE   = 8'h03;
   localparam logic [7:0] CMD_RAIL_SELECT       = 8'h04;

   // Start/stop configuration byte layout
   localparam int         CFG_AUTOSTART_BIT = 4;
   localparam int         CFG_RUN_HONOR_BIT = 3;
   localparam int         CFG_PIN_HONOR_BIT = 2;
   localparam int         CFG_POLARITY_BIT  = 1;
   localparam int         CFG_FAST_OFF_BIT  = 0;
   localparam logic [7:0] CFG_WRITE_MASK    = 8'h1f;
   // Stored copy normally comes from NVM; plain default here
   localparam logic [7:0] CFG_RESET         = 8'h16;

   // Rail selector values
   localparam logic [7:0] RAIL_ALL       = 8'hff;
   localparam logic [7:0] RAIL_LAST      = 8'h03;
   localparam logic [7:0] RAIL_RESET     = 8'hff;
   localparam logic [1:0] CONTROLLER_POS = 2'h0;

   localparam int         FAULT_W = 8;
   localparam int         TIME_W  = 16;
   localparam int         SYNC_W  = 6;

   typedef struct packed {
      logic       valid;
      logic       write;
      logic       has_data;
      logic [7:0] code;
      logic [7:0] data;
   } pmcmd_req_t;

   typedef struct packed {
      logic       valid;
      logic       refused;
      logic [7:0] data;
   } pmcmd_rsp_t;

   typedef enum logic [3:0] {
      ST_OFF  = 4'h1,
      ST_RUN  = 4'h2,
      ST_HOLD = 4'h4,
      ST_RAMP = 4'h8
   } pmcmd_state_t;

endpackage

/* File: pmcmd_onoff_fault_phase.sv */
`timescale 1ns/100ps
// Function
// - Config bits 7:5 read zero, writes ignored
// - Autostart clear: convert whenever input power present
// - Autostart set: pin and/or run command decide
// - Bit 3 selects obeying the run command
// - Bit 2 clear: ignore pin, no undervoltage
// - Bit 2 set: obey pin, plus run command if bit 3 set
// - Bit 1 sets pin polarity; undervoltage needs high
// - Bit 0 clear: hold, then ramp down on pin off
// - Bit 0 set: pin off stops at once
// - Enable/undervoltage pin is the control pin
// - Data-less config write flags invalid data, alerts host
// - Fault wipe is data-less send-byte 03h, unreadable
// - Fault wipe clears status of selected or all
// - Fault wipe releases the alert output
// - Fault wipe never restarts a latched-off unit
// - Fault still present sets bit and alerts again
// - Alert response releases alert, keeps status bits
// - Pre-answer sources blocked until cleared; new ones alert
// - Rail selector at 04h steers phased commands
// - Selector 00h-03h one phase, FFh all, else invalid
// - Controller is phase 00h, followers use stack position
// - Selector unsupported by stacking flags invalid data
// - Run command bit 7 switches conversion when required
module pmcmd_onoff_fault_phase
   import pmcmd_pkg::*;
(
   input  wire logic               i_clock,
   input  wire logic               i_rst,
   input  wire pmcmd_req_t         i_req,
   output pmcmd_rsp_t              o_rsp,
   input  wire logic               i_ara_answered,
   input  wire logic               i_enable_undervoltage_pin,
   input  wire logic               i_ground_sense_role_pin,
   input  wire logic [1:0]         i_stack_position_setting,
   input  wire logic [1:0]         i_stack_phase_count_m1,
   input  wire logic               i_input_power_ok,
   input  wire logic               i_run_command,
   input  wire logic               i_fault_latched_off,
   input  wire logic [FAULT_W-1:0] i_fault_src,
   input  wire logic [TIME_W-1:0]  i_stop_hold_time,
   input  wire logic [TIME_W-1:0]  i_stop_ramp_time,
   output logic                    o_convert_on,
   output logic                    o_ramp_down,
   output logic                    o_uvlo_active,
   output logic [FAULT_W-1:0]      o_status_faults,
   output logic                    o_invalid_data,
   output logic [7:0]              o_rail_select,
   output logic [1:0]              o_own_phase,
   output logic                    o_alert_out,
   output logic                    o_alert_oe_n
);

   // Selector addresses this device when it names us or all phases
   function automatic logic phase_hit(input logic [7:0] sel,
                                      input logic [1:0] own);
      phase_hit = (sel == RAIL_ALL) || (sel == {6'h00, own});
   endfunction

   logic [SYNC_W-1:0]  pin_meta_q;
   logic [SYNC_W-1:0]  pin_sync_q;
   logic               strap_meta_q;
   logic               strap_ok_q;
   logic               straps_taken_q;
   logic [1:0]         own_phase_q;
   logic [1:0]         phase_cnt_m1_q;
   logic [7:0]         cfg_q;
   logic [7:0]         rail_q;
   logic [FAULT_W-1:0] status_q;
   logic [FAULT_W-1:0] status_d;
   logic [FAULT_W-1:0] blocked_q;
   logic [FAULT_W-1:0] src_prev_q;
   logic               invalid_q;
   logic               alert_q;
   pmcmd_state_t       st_q;
   pmcmd_state_t       st_d;
   logic [TIME_W-1:0]  cnt_q;
   logic [TIME_W-1:0]  cnt_d;
   pmcmd_rsp_t         rsp_q;

   logic wr_cfg;
   logic wr_rail;
   logic wipe;
   logic wipe_hit;
   logic bad_write;
   logic rail_ok;
   logic pin_level;
   logic pin_on;
   logic run_ok;
   logic want_on;
   logic pin_off_cause;
   logic off_on_edge;
   logic [FAULT_W-1:0] fresh;

   // Pins are asynchronous to i_clock
   always_ff @(posedge i_clock) begin
      if (i_rst) begin
         pin_meta_q <= '0;
         pin_sync_q <= '0;
      end else begin
         pin_meta_q <= {i_stack_phase_count_m1, i_stack_position_setting,
                        i_ground_sense_role_pin, i_enable_undervoltage_pin};
         pin_sync_q <= pin_meta_q;
      end
   end

   assign pin_level = pin_sync_q[0];

   always_ff @(posedge i_clock) begin
      if (i_rst) begin
         strap_meta_q   <= 1'b0;
         strap_ok_q     <= 1'b0;
         straps_taken_q <= 1'b0;
         own_phase_q    <= CONTROLLER_POS;
         phase_cnt_m1_q <= 2'h0;
      end else begin
         // Marker runs beside the synchroniser so the capture never
         // takes its reset value
         strap_meta_q <= 1'b1;
         strap_ok_q   <= strap_meta_q;
         if (strap_ok_q && !straps_taken_q) begin
            straps_taken_q <= 1'b1;
            own_phase_q    <= pin_sync_q[1] ? pin_sync_q[3:2] :
                              CONTROLLER_POS;
            phase_cnt_m1_q <= pin_sync_q[5:4];
         end
      end
   end

   // Command decode
   assign wr_cfg  = i_req.valid && i_req.write &&
                    (i_req.code == CMD_START_STOP_CONFIG);
   assign wr_rail = i_req.valid && i_req.write &&
                    (i_req.code == CMD_RAIL_SELECT);
   assign wipe    = i_req.valid && i_req.write && !i_req.has_data &&
                    (i_req.code == CMD_FAULT_FLAG_WIPE);
   assign wipe_hit = wipe && phase_hit(rail_q, own_phase_q);

   assign rail_ok = (i_req.data == RAIL_ALL) ||
                    ((i_req.data <= RAIL_LAST) &&
                     (i_req.data[1:0] <= phase_cnt_m1_q));

   // wrong form or unsupported value is invalid data
   assign bad_write = (wr_cfg && !i_req.has_data) ||
                      (wr_rail && (!i_req.has_data || !rail_ok)) ||
                      (i_req.valid && i_req.write && i_req.has_data &&
                       (i_req.code == CMD_FAULT_FLAG_WIPE));

   always_ff @(posedge i_clock) begin
      if (i_rst) begin
         cfg_q <= CFG_RESET & CFG_WRITE_MASK;
      end else if (wr_cfg && i_req.has_data) begin
         cfg_q <= i_req.data & CFG_WRITE_MASK;
      end
   end

   always_ff @(posedge i_clock) begin
      if (i_rst) begin
         rail_q <= RAIL_RESET;
      end else if (wr_rail && i_req.has_data && rail_ok) begin
         rail_q <= i_req.data;
      end
   end

   // Read answers one cycle after the request
   always_ff @(posedge i_clock) begin
      if (i_rst) begin
         rsp_q <= '0;
      end else begin
         rsp_q.valid   <= i_req.valid && !i_req.write;
         rsp_q.refused <= 1'b0;
         rsp_q.data    <= 8'h00;
         if (i_req.valid && !i_req.write) begin
            case (i_req.code)
               CMD_START_STOP_CONFIG: rsp_q.data <= cfg_q;
               CMD_RAIL_SELECT:       rsp_q.data <= rail_q;
               default:               rsp_q.refused <= 1'b1;
            endcase
         end
      end
   end

   // Start/stop request
   // polarity
   assign pin_on = cfg_q[CFG_POLARITY_BIT] ? pin_level : !pin_level;
   assign run_ok = !cfg_q[CFG_RUN_HONOR_BIT] || i_run_command;
   // pin ignored when bit 2 clear
   // pin obeyed when bit 2 set
   assign want_on = i_input_power_ok && !i_fault_latched_off &&
                    (!cfg_q[CFG_AUTOSTART_BIT] ||
                     (run_ok && (!cfg_q[CFG_PIN_HONOR_BIT] || pin_on)));
   assign pin_off_cause = cfg_q[CFG_AUTOSTART_BIT] &&
                          cfg_q[CFG_PIN_HONOR_BIT] && !pin_on &&
                          run_ok && i_input_power_ok &&
                          !i_fault_latched_off;
   assign o_uvlo_active = cfg_q[CFG_PIN_HONOR_BIT] &&
                          cfg_q[CFG_POLARITY_BIT];

   always_comb begin
      st_d  = st_q;
      cnt_d = cnt_q;
      case (st_q)
         ST_OFF: begin
            if (want_on) begin
               st_d = ST_RUN;
            end
         end
         ST_RUN: begin
            if (!want_on) begin
               if (pin_off_cause && !cfg_q[CFG_FAST_OFF_BIT]) begin
                  st_d  = ST_HOLD;
                  cnt_d = i_stop_hold_time;
               end else begin
                  st_d = ST_OFF;
               end
            end
         end
         ST_HOLD: begin
            if (want_on) begin
               st_d = ST_RUN;
            end else if (!pin_off_cause) begin
               st_d = ST_OFF;
            end else if (cnt_q == '0) begin
               st_d  = ST_RAMP;
               cnt_d = i_stop_ramp_time;
            end else begin
               cnt_d = cnt_q - 1'b1;
            end
         end
         ST_RAMP: begin
            // Ramp finishes before a new start; simpler sequencing
            if (!i_input_power_ok || i_fault_latched_off ||
                cnt_q == '0) begin
               st_d = ST_OFF;
            end else begin
               cnt_d = cnt_q - 1'b1;
            end
         end
         default: begin
            st_d = ST_OFF;
         end
      endcase
   end

   always_ff @(posedge i_clock) begin
      if (i_rst) begin
         st_q  <= ST_OFF;
         cnt_q <= '0;
      end else begin
         st_q  <= st_d;
         cnt_q <= cnt_d;
      end
   end

   assign off_on_edge = (st_q == ST_OFF) && (st_d == ST_RUN);

   // Status: sources are levels, so a still-present fault sets again
   // set wins over wipe
   always_comb begin
      status_d = status_q;
      if (wipe_hit) begin
         status_d = '0;
      end
      status_d = status_d | i_fault_src;
   end

   always_ff @(posedge i_clock) begin
      if (i_rst) begin
         status_q   <= '0;
         src_prev_q <= '0;
      end else begin
         status_q   <= status_d;
         src_prev_q <= i_fault_src;
      end
   end

   // sources seen before the answer stay blocked
   always_ff @(posedge i_clock) begin
      if (i_rst) begin
         blocked_q <= '0;
      end else if (i_ara_answered) begin
         blocked_q <= blocked_q | status_q | i_fault_src;
      end else if (wipe_hit || off_on_edge) begin
         blocked_q <= '0;
      end
   end

   // New source activations that may raise the alert
   assign fresh = (i_fault_src & ~src_prev_q & ~blocked_q) |
                  (wipe_hit ? i_fault_src : '0);

   // invalid data flag, set wins over wipe
   always_ff @(posedge i_clock) begin
      if (i_rst) begin
         invalid_q <= 1'b0;
      end else if (bad_write) begin
         invalid_q <= 1'b1;
      end else if (wipe_hit) begin
         invalid_q <= 1'b0;
      end
   end

   always_ff @(posedge i_clock) begin
      if (i_rst) begin
         alert_q <= 1'b0;
      end else if ((|fresh) || bad_write) begin
         alert_q <= 1'b1;
      end else if (wipe_hit || i_ara_answered) begin
         alert_q <= 1'b0;
      end
   end

   assign o_rsp           = rsp_q;
   assign o_convert_on    = (st_q != ST_OFF);
   assign o_ramp_down     = (st_q == ST_RAMP);
   assign o_status_faults = status_q;
   assign o_invalid_data  = invalid_q;
   assign o_rail_select   = rail_q;
   assign o_own_phase     = own_phase_q;
   assign o_alert_out     = 1'b0;
   assign o_alert_oe_n    = !alert_q;

   default clocking cb @(posedge i_clock); endclocking
   default disable iff (i_rst);

   chk_cfg_upper_zero: assert property (
      rsp_q.valid && ($past(i_req.code) == CMD_START_STOP_CONFIG)
      |-> (rsp_q.data[7:5] == 3'h0))
      else $error("Config upper bits not zero");

   chk_autostart_start: assert property (
      (st_q == ST_OFF) && !cfg_q[CFG_AUTOSTART_BIT] && i_input_power_ok &&
      !i_fault_latched_off |=> o_convert_on)
      else $error("Autostart did not start conversion");

   chk_pin_fast_off: assert property (
      (st_q == ST_RUN) && pin_off_cause && cfg_q[CFG_FAST_OFF_BIT]
      |=> !o_convert_on)
      else $error("Pin off did not stop at once");

   chk_pin_soft_off: assert property (
      (st_q == ST_RUN) && pin_off_cause && !cfg_q[CFG_FAST_OFF_BIT]
      |=> (st_q == ST_HOLD) && o_convert_on && !o_ramp_down)
      else $error("Pin off did not hold regulation");

   chk_uvlo_follow: assert property (
      wr_cfg && i_req.has_data |=> ##1
      (o_uvlo_active == ($past(i_req.data[2], 2) && $past(i_req.data[1], 2))))
      else $error("Undervoltage enable wrong after write");

   chk_wipe_clears: assert property (
      wipe_hit && (i_fault_src == '0) && !i_ara_answered
      |=> (o_status_faults == '0) && o_alert_oe_n)
      else $error("Fault wipe did not clear status");

   chk_latched_stays: assert property (
      (st_q == ST_OFF) && i_fault_latched_off |=> !o_convert_on)
      else $error("Latched-off unit restarted");

   chk_answer_keeps: assert property (
      i_ara_answered && !wipe_hit && (i_fault_src == '0) && !bad_write
      |=> o_alert_oe_n && (o_status_faults == $past(status_q)))
      else $error("Alert answer mishandled status");

   chk_rail_invalid: assert property (
      wr_rail && i_req.has_data && (i_req.data > RAIL_LAST) &&
      (i_req.data != RAIL_ALL)
      |=> o_invalid_data && (o_rail_select == $past(rail_q)) && !o_alert_oe_n)
      else $error("Invalid selector accepted");

   chk_wipe_unread: assert property (
      i_req.valid && !i_req.write && (i_req.code == CMD_FAULT_FLAG_WIPE)
      |=> o_rsp.valid && o_rsp.refused)
      else $error("Fault wipe read not refused");

endmodule // pmcmd_onoff_fault_phase

/* File: pmcmd_host_model.sv */
`timescale 1ns/100ps
module pmcmd_host_model
   import pmcmd_pkg::*;
(
   input  wire logic       i_clock,
   input  wire pmcmd_rsp_t i_rsp,
   output pmcmd_req_t      o_req,
   output logic            o_ara_answered
);
   initial begin
      o_req          = '0;
      o_ara_answered = 1'b0;
   end

   task automatic xfer(input logic w, input logic hd, input logic [7:0] c,
                       input logic [7:0] d);
      @(posedge i_clock);
      #1;
      o_req = '{valid: 1'b1, write: w, has_data: hd, code: c, data: d};
      @(posedge i_clock);
      #1;
      // Idle data shows the inverse so a stale byte is never mistaken
      o_req.valid = 1'b0;
      o_req.data  = ~d;
   endtask

   task automatic rd(input logic [7:0] c, output logic [7:0] d,
                     output logic rf);
      int k;
      xfer(1'b0, 1'b0, c, 8'h00);
      for (k = 0; k < 3 && i_rsp.valid !== 1'b1; k++) begin
         @(posedge i_clock);
         #1;
      end
      d  = (i_rsp.valid === 1'b1) ? i_rsp.data : 8'hxx;
      rf = i_rsp.refused;
   endtask

   task automatic ara_pulse;
      @(posedge i_clock);
      #1;
      o_ara_answered = 1'b1;
      @(posedge i_clock);
      #1;
      o_ara_answered = 1'b0;
   endtask
endmodule // pmcmd_host_model

/* File: tb.sv */
`timescale 1ns/100ps
module tb import pmcmd_pkg::*;;
   logic               i_clock = 1'b0;
   logic               i_rst;
   pmcmd_req_t         req;
   pmcmd_rsp_t         rsp;
   logic               ara;
   logic               pin;
   logic               gsr;
   logic               pwr;
   logic               run;
   logic               lat;
   logic [FAULT_W-1:0] src;
   logic               conv;
   logic               ramp;
   logic               uvlo;
   logic [FAULT_W-1:0] stat;
   logic               inv;
   logic [7:0]         rail;
   logic [1:0]         own;
   logic               aout;
   logic               aoe_n;
   int                 err_total = 0;
   int                 check_count = 0;

   always #2 i_clock = ~i_clock;

   pmcmd_onoff_fault_phase dut (
      .i_clock                   (i_clock),
      .i_rst                     (i_rst),
      .i_req                     (req),
      .o_rsp                     (rsp),
      .i_ara_answered            (ara),
      .i_enable_undervoltage_pin (pin),
      .i_ground_sense_role_pin   (gsr),
      .i_stack_position_setting  (2'h2),
      .i_stack_phase_count_m1    (2'h2),
      .i_input_power_ok          (pwr),
      .i_run_command             (run),
      .i_fault_latched_off       (lat),
      .i_fault_src               (src),
      .i_stop_hold_time          (16'h0005),
      .i_stop_ramp_time          (16'h0004),
      .o_convert_on              (conv),
      .o_ramp_down               (ramp),
      .o_uvlo_active             (uvlo),
      .o_status_faults           (stat),
      .o_invalid_data            (inv),
      .o_rail_select             (rail),
      .o_own_phase               (own),
      .o_alert_out               (aout),
      .o_alert_oe_n              (aoe_n)
   );

   pmcmd_host_model host (
      .i_clock        (i_clock),
      .i_rsp          (rsp),
      .o_req          (req),
      .o_ara_answered (ara)
   );

   task automatic chk1(input string n, input logic e, input logic g);
      check_count++;
      if (g !== e) begin
         err_total++;
         $display("Error %s expected %b seen %b", n, e, g);
      end
   endtask

   task automatic chk8(input string n, input logic [7:0] e,
                       input logic [7:0] g);
      check_count++;
      if (g !== e) begin
         err_total++;
         $display("Error %s expected %h seen %h", n, e, g);
      end
   endtask

   task automatic cyc(input int n);
      repeat (n) @(posedge i_clock);
      #1;
   endtask

   task automatic wr(input logic [7:0] c, input logic [7:0] d);
      host.xfer(1'b1, 1'b1, c, d);
   endtask

   task automatic wipe;
      host.xfer(1'b1, 1'b0, CMD_FAULT_FLAG_WIPE, 8'h00);
   endtask

   task automatic rdchk(input logic [7:0] c, input logic [7:0] e,
                        input logic rf_e);
      logic [7:0] d;
      logic       rf;
      host.rd(c, d, rf);
      chk8("read data", e, d);
      chk1("refused", rf_e, rf);
   endtask

   task automatic final_report;
      $display("Checks %0d errors %0d", check_count, err_total);
      if (err_total == 0 && check_count > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask

   initial begin
      #20000;
      err_total++;
      final_report();
   end

   initial begin
      i_rst = 1'b1;
      pin   = 1'b0;
      gsr   = 1'b0;
      pwr   = 1'b1;
      run   = 1'b0;
      lat   = 1'b0;
      src   = '0;
      repeat (12) @(posedge i_clock);
      #1;
      i_rst = 1'b0;
      chk8("rail", RAIL_RESET, rail);
      chk1("alert_oe_n", 1'b1, aoe_n);
      cyc(4);
      chk8("own_phase", 8'h00, {6'h00, own});
      rdchk(CMD_START_STOP_CONFIG, CFG_RESET, 1'b0);
      wr(CMD_START_STOP_CONFIG, 8'hff);
      cyc(1);
      rdchk(CMD_START_STOP_CONFIG, 8'h1f, 1'b0);
      chk1("invalid", 1'b0, inv);
      // Autostart clear follows input power alone
      wr(CMD_START_STOP_CONFIG, 8'h00);
      cyc(4);
      chk1("conv", 1'b1, conv);
      pwr = 1'b0;
      cyc(4);
      chk1("conv", 1'b0, conv);
      pwr = 1'b1;
      wr(CMD_START_STOP_CONFIG, 8'h18);
      cyc(4);
      chk1("uvlo", 1'b0, uvlo);
      chk1("conv", 1'b0, conv);
      run = 1'b1;
      cyc(4);
      chk1("conv", 1'b1, conv);
      run = 1'b0;
      cyc(4);
      chk1("conv", 1'b0, conv);
      wr(CMD_START_STOP_CONFIG, 8'h14);
      cyc(4);
      chk1("conv", 1'b1, conv);
      chk1("uvlo", 1'b0, uvlo);
      wr(CMD_START_STOP_CONFIG, 8'h16);
      cyc(20);
      pin = 1'b1;
      cyc(4);
      chk1("conv", 1'b1, conv);
      chk1("uvlo", 1'b1, uvlo);
      // Soft stop: 2 sync edges, hold 6 cycles, then ramp 5 cycles
      pin = 1'b0;
      cyc(8);
      chk1("conv", 1'b1, conv);
      chk1("ramp", 1'b0, ramp);
      cyc(1);
      chk1("ramp", 1'b1, ramp);
      cyc(4);
      chk1("conv", 1'b1, conv);
      cyc(1);
      chk1("conv", 1'b0, conv);
      wr(CMD_START_STOP_CONFIG, 8'h17);
      pin = 1'b1;
      cyc(4);
      chk1("conv", 1'b1, conv);
      pin = 1'b0;
      cyc(2);
      chk1("conv", 1'b1, conv);
      cyc(1);
      chk1("conv", 1'b0, conv);
      pin = 1'b1;
      cyc(4);
      lat = 1'b1;
      cyc(2);
      wipe();
      cyc(3);
      chk1("conv", 1'b0, conv);
      pin = 1'b0;
      lat = 1'b0;
      host.xfer(1'b1, 1'b0, CMD_START_STOP_CONFIG, 8'h00);
      cyc(1);
      chk1("invalid", 1'b1, inv);
      chk1("alert_oe_n", 1'b0, aoe_n);
      rdchk(CMD_START_STOP_CONFIG, 8'h17, 1'b0);
      wipe();
      cyc(1);
      chk1("invalid", 1'b0, inv);
      chk1("alert_oe_n", 1'b1, aoe_n);
      wr(CMD_RAIL_SELECT, 8'h03);
      cyc(1);
      chk1("invalid", 1'b1, inv);
      chk8("rail", 8'hff, rail);
      wipe();
      wr(CMD_RAIL_SELECT, 8'h05);
      cyc(1);
      chk1("invalid", 1'b1, inv);
      chk8("rail", 8'hff, rail);
      wipe();
      wr(CMD_RAIL_SELECT, 8'h02);
      cyc(1);
      chk8("rail", 8'h02, rail);
      rdchk(CMD_RAIL_SELECT, 8'h02, 1'b0);
      rdchk(CMD_FAULT_FLAG_WIPE, 8'h00, 1'b1);
      src = 8'h01;
      cyc(2);
      src = 8'h00;
      // Selector names another phase, so this wipe must not act
      wipe();
      cyc(1);
      chk8("status", 8'h01, stat);
      wr(CMD_RAIL_SELECT, RAIL_ALL);
      wipe();
      cyc(1);
      chk8("status", 8'h00, stat);
      chk1("alert_oe_n", 1'b1, aoe_n);
      src = 8'h01;
      cyc(2);
      chk1("alert_oe_n", 1'b0, aoe_n);
      host.ara_pulse();
      cyc(2);
      chk1("alert_oe_n", 1'b1, aoe_n);
      chk8("status", 8'h01, stat);
      cyc(3);
      chk1("alert_oe_n", 1'b1, aoe_n);
      // A source seen before the answer stays blocked when it returns
      src = 8'h00;
      cyc(2);
      src = 8'h01;
      cyc(2);
      chk1("alert_oe_n", 1'b1, aoe_n);
      src = 8'h03;
      cyc(2);
      chk1("alert_oe_n", 1'b0, aoe_n);
      host.ara_pulse();
      wipe();
      cyc(2);
      chk8("status", 8'h03, stat);
      chk1("alert_oe_n", 1'b0, aoe_n);
      src = 8'h00;
      wipe();
      cyc(2);
      chk8("status", 8'h00, stat);
      chk1("alert_oe_n", 1'b1, aoe_n);
      chk1("alert_out", 1'b0, aout);
      // Second reset as a follower: strap position becomes own phase
      gsr   = 1'b1;
      i_rst = 1'b1;
      cyc(2);
      i_rst = 1'b0;
      chk8("rail", RAIL_RESET, rail);
      chk1("alert_oe_n", 1'b1, aoe_n);
      cyc(4);
      chk8("own_phase", 8'h02, {6'h00, own});
      final_report();
   end
endmodule // tb
